// ---- src/i2cb_pkg.sv ----
// shared constants and types for the two-wire byte controller
package i2cb_pkg;

	// ****************************************
	// register map (byte addresses)
	// ****************************************
	localparam logic [7:0] OFS_DATA = 8'h00;
	localparam logic [7:0] OFS_CTRL = 8'h04;
	localparam logic [7:0] OFS_STAT = 8'h08;
	localparam logic [7:0] OFS_ADDR = 8'h0c;
	localparam logic [7:0] OFS_DIV = 8'h10;

	// ****************************************
	// field positions
	// ****************************************
	localparam int CB_EN = 7;
	localparam int CB_MST = 5;
	localparam int CB_TX = 4;
	localparam int CB_ACK_DRIVE_VALUE = 3;
	localparam int CB_RSTA = 2;
	localparam int SB_TCF = 7;
	localparam int SB_IAAS = 6;
	localparam int SB_BUSY = 5;
	localparam int SB_ARBITRATION_LOST_FLAG = 4;
	localparam int SB_SRW = 2;
	localparam int SB_RXAK = 0;
	localparam int AB_LSB = 1;

	// ****************************************
	// reset values and counts
	// ****************************************
	localparam logic [7:0] DATA_RST = 8'h00;
	localparam logic [6:0] ADDR_RST = 7'h00;
	localparam logic [15:0] DIV_RST = 16'h01f4;
	localparam logic [3:0] BIT_ACK = 4'h8;
	localparam logic [3:0] BIT_LAST = 4'h7;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [3:0] {
		SG_IDLE, SG_START, SG_LOW, SG_HIGH, SG_STOP1, SG_STOP2, SG_STOP3,
		SG_RS1, SG_RS2
	} i2cb_sg_t;

	typedef enum logic [1:0] {PH_IDLE, PH_XFER, PH_HOLD} i2cb_ph_t;

	typedef struct packed {
		logic scl;
		logic sda;
	} i2cb_line_t;

	typedef struct packed {
		logic scl_rise;
		logic scl_fall;
		logic start;
		logic stop;
	} i2cb_evt_t;

endpackage

// ---- src/i2cb_sync.sv ----
// two-flop synchroniser for the bus lines
`timescale 1ns/1ps
module i2cb_sync import i2cb_pkg::*; (
	input wire logic clk,
	input wire logic rst_n,
	input wire i2cb_line_t d,
	output i2cb_line_t q
);
	typedef struct packed {
		i2cb_line_t s1;
		i2cb_line_t s2;
	} i2cb_sync_st_t;

	i2cb_sync_st_t st_q, st_d;

	always_comb begin
		st_d = st_q;
		st_d.s1 = d;
		st_d.s2 = st_q.s1;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= '1;
		end else begin
			st_q <= st_d;
		end
	end

	assign q = st_q.s2;
endmodule

// ---- src/i2cb_cond.sv ----
// edge, start and stop detection on synchronised lines
`timescale 1ns/1ps
module i2cb_cond import i2cb_pkg::*; (
	input wire logic clk,
	input wire logic rst_n,
	input wire i2cb_line_t line,
	output i2cb_evt_t evt
);
	typedef struct packed {
		i2cb_line_t prev;
	} i2cb_cond_st_t;

	i2cb_cond_st_t st_q, st_d;

	always_comb begin
		st_d = st_q;
		st_d.prev = line;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= '1;
		end else begin
			st_q <= st_d;
		end
	end

	// sda changing while scl stays high marks start or stop
	assign evt.scl_rise = line.scl & ~st_q.prev.scl;
	assign evt.scl_fall = ~line.scl & st_q.prev.scl;
	assign evt.start = line.scl & st_q.prev.scl & st_q.prev.sda & ~line.sda;
	assign evt.stop = line.scl & st_q.prev.scl & ~st_q.prev.sda & line.sda;
endmodule

// ---- src/i2cb_top.sv ----
// two-wire bus byte controller with apb register access
`timescale 1ns/1ps
module i2cb_top import i2cb_pkg::*; (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe
);
	typedef struct packed {
		logic en;
		logic master_select;
		logic tx;
		logic ack_drive_value;
		logic [6:0] own;
		logic [15:0] div;
		logic transfer_complete_flag;
		logic iaas;
		logic busy;
		logic arbitration_lost_flag;
		logic srw;
		logic rxak;
		logic [7:0] rxd;
		logic [7:0] shr;
		logic [3:0] cnt;
		i2cb_ph_t ph;
		i2cb_sg_t sg;
		logic master;
		logic xmit;
		logic adr;
		logic sda_drv;
		logic stop_req;
		logic rs_req;
		logic [15:0] tmr;
		logic [31:0] prdata;
	} i2cb_st_t;

	i2cb_st_t q, d;
	i2cb_line_t raw, line;
	i2cb_evt_t ev;
	logic acc;
	logic hit;
	logic lost;
	logic tmr_end;
	logic stopping;
	logic [7:0] byte_in;
	logic [7:0] ctrl_rd;
	logic [7:0] stat_rd;

	// ****************************************
	// line synchronisation and events
	// ****************************************
	assign raw.scl = scl_i;
	assign raw.sda = sda_i;

	i2cb_sync u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.d(raw),
		.q(line)
	);

	i2cb_cond u_cond (
		.clk(clk),
		.rst_n(rst_n),
		.line(line),
		.evt(ev)
	);

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		d = q;
		lost = 1'b0;
		acc = psel & penable;
		hit = (paddr == OFS_DATA) | (paddr == OFS_CTRL) |
			(paddr == OFS_STAT) | (paddr == OFS_ADDR) | (paddr == OFS_DIV);
		tmr_end = q.tmr >= q.div;
		stopping = (q.sg == SG_STOP1) | (q.sg == SG_STOP2) |
			(q.sg == SG_STOP3);
		byte_in = {q.shr[6:0], line.sda};
		ctrl_rd = 8'h00;
		ctrl_rd[CB_EN] = q.en;
		ctrl_rd[CB_MST] = q.master_select;
		ctrl_rd[CB_TX] = q.tx;
		ctrl_rd[CB_ACK_DRIVE_VALUE] = q.ack_drive_value;
		stat_rd = 8'h00;
		stat_rd[SB_TCF] = q.transfer_complete_flag;
		stat_rd[SB_IAAS] = q.iaas;
		stat_rd[SB_BUSY] = q.busy;
		stat_rd[SB_ARBITRATION_LOST_FLAG] = q.arbitration_lost_flag;
		stat_rd[SB_SRW] = q.srw;
		stat_rd[SB_RXAK] = q.rxak;

		// read data is captured in the setup cycle
		if (psel & ~penable) begin
			case (paddr)
				OFS_DATA: d.prdata = {24'h000000, q.rxd};
				OFS_CTRL: d.prdata = {24'h000000, ctrl_rd};
				OFS_STAT: d.prdata = {24'h000000, stat_rd};
				OFS_ADDR: d.prdata = {24'h000000, q.own, 1'b0};
				OFS_DIV: d.prdata = {16'h0000, q.div};
				default: d.prdata = 32'h00000000;
			endcase
		end

		// ****************************************
		// software accesses
		// ****************************************
		if (acc & pwrite) begin
			case (paddr)
				OFS_CTRL: begin
					d.en = pwdata[CB_EN];
					d.tx = pwdata[CB_TX];
					d.ack_drive_value = pwdata[CB_ACK_DRIVE_VALUE];
					d.iaas = 1'b0;
					if (pwdata[CB_MST] & ~q.master_select) begin
						if (q.busy) begin
							d.arbitration_lost_flag = 1'b1;
						end else begin
							d.master_select = 1'b1;
							d.master = 1'b1;
							d.sg = SG_START;
							d.ph = PH_HOLD;
							d.adr = 1'b1;
							d.sda_drv = 1'b1;
							d.tmr = 16'h0000;
						end
					end else if (~pwdata[CB_MST] & q.master_select) begin
						d.master_select = 1'b0;
						d.stop_req = 1'b1;
					end
					if (pwdata[CB_RSTA]) begin
						if (q.master) begin
							d.rs_req = 1'b1;
						end else begin
							d.arbitration_lost_flag = 1'b1;
						end
					end
				end
				OFS_STAT: begin
					if (pwdata[SB_ARBITRATION_LOST_FLAG]) begin
						d.arbitration_lost_flag = 1'b0;
					end
				end
				OFS_ADDR: d.own = pwdata[7:AB_LSB];
				OFS_DIV: d.div = pwdata[15:0];
				OFS_DATA: begin
					if (q.tx) begin
						d.transfer_complete_flag = 1'b0;
						if (q.master & q.adr & (pwdata[7:AB_LSB] == q.own)) begin
							d.arbitration_lost_flag = 1'b1;
							d.master_select = 1'b0;
							d.stop_req = 1'b1;
						end else if (q.ph == PH_HOLD) begin
							d.shr = pwdata[7:0];
							d.cnt = 4'h0;
							d.ph = PH_XFER;
							d.xmit = 1'b1;
							if (~q.master | (q.sg == SG_LOW)) begin
								d.sda_drv = ~pwdata[7];
							end
							d.tmr = 16'h0000;
						end
					end
				end
				default: ;
			endcase
		end
		if (acc & ~pwrite & (paddr == OFS_DATA) & ~q.tx) begin
			d.transfer_complete_flag = 1'b0;
			if ((q.ph == PH_HOLD) & ~q.adr) begin
				d.cnt = 4'h0;
				d.ph = PH_XFER;
				d.xmit = 1'b0;
				d.sda_drv = 1'b0;
				d.tmr = 16'h0000;
			end
		end

		// ****************************************
		// bus conditions
		// ****************************************
		if (ev.start) begin
			d.busy = 1'b1;
			if (~q.master) begin
				d.ph = PH_XFER;
				d.cnt = 4'h0;
				d.adr = 1'b1;
				d.xmit = 1'b0;
				d.iaas = 1'b0;
				d.sda_drv = 1'b0;
			end
		end
		if (ev.stop) begin
			d.busy = 1'b0;
			if (q.master & ~stopping) begin
				d.arbitration_lost_flag = 1'b1;
				d.master = 1'b0;
				d.master_select = 1'b0;
				d.sg = SG_IDLE;
			end
			if (~q.master) begin
				d.ph = PH_IDLE;
				d.sda_drv = 1'b0;
			end
		end

		// ****************************************
		// bit engine, shared by master and slave
		// ****************************************
		if (ev.scl_rise & (q.ph == PH_XFER) & (q.sg != SG_RS2)) begin
			if (q.cnt < BIT_ACK) begin
				d.shr = byte_in;
				lost = q.master & q.xmit & ~q.sda_drv & ~line.sda;
			end else if (q.cnt == BIT_ACK) begin
				if (q.xmit) begin
					d.rxak = line.sda;
				end else begin
					lost = q.master & ~q.sda_drv & ~line.sda;
				end
			end
			if (q.cnt <= BIT_ACK) begin
				d.cnt = q.cnt + 4'h1;
			end
			if (lost) begin
				d.master = 1'b0;
				d.master_select = 1'b0;
				d.arbitration_lost_flag = 1'b1;
				d.sda_drv = 1'b0;
				d.xmit = 1'b0;
				d.sg = SG_IDLE;
				d.stop_req = 1'b0;
				d.rs_req = 1'b0;
			end
			if ((q.cnt == BIT_LAST) & ~d.master & ~q.xmit) begin
				if (q.adr) begin
					if (byte_in[7:AB_LSB] == q.own) begin
						d.iaas = 1'b1;
						d.srw = byte_in[0];
					end else begin
						d.ph = PH_IDLE;
					end
				end
			end
			if ((q.cnt == BIT_LAST) & ~q.xmit & ~q.adr) begin
				d.rxd = byte_in;
			end
		end
		if (ev.scl_fall & (q.ph == PH_XFER)) begin
			if (q.cnt < BIT_ACK) begin
				d.sda_drv = q.xmit & ~q.shr[7];
			end else if (q.cnt == BIT_ACK) begin
				d.sda_drv = ~q.xmit & (q.adr ? q.iaas : ~q.ack_drive_value);
			end else begin
				d.transfer_complete_flag = 1'b1;
				d.sda_drv = 1'b0;
				d.cnt = 4'h0;
				d.adr = 1'b0;
				if (~q.master & (~q.iaas | (q.xmit & q.rxak))) begin
					d.ph = PH_IDLE;
				end else begin
					d.ph = PH_HOLD;
				end
			end
		end

		// ****************************************
		// master clock generator
		// ****************************************
		if (~tmr_end) begin
			d.tmr = q.tmr + 16'h0001;
		end
		case (q.sg)
			SG_IDLE: ;
			SG_START: begin
				if (tmr_end) begin
					d.sg = SG_LOW;
					d.tmr = 16'h0000;
				end
			end
			SG_LOW: begin
				if (tmr_end & (q.ph == PH_XFER)) begin
					d.sg = SG_HIGH;
					d.tmr = 16'h0000;
				end else if (tmr_end & q.stop_req) begin
					d.sg = SG_STOP1;
					d.sda_drv = 1'b1;
					d.stop_req = 1'b0;
					d.ph = PH_IDLE;
					d.tmr = 16'h0000;
				end else if (tmr_end & q.rs_req) begin
					d.sg = SG_RS1;
					d.sda_drv = 1'b0;
					d.adr = 1'b1;
					d.cnt = 4'h0;
					d.rs_req = 1'b0;
					d.tmr = 16'h0000;
				end
			end
			SG_HIGH: begin
				if (ev.scl_fall | (line.scl & tmr_end)) begin
					d.sg = SG_LOW;
					d.tmr = 16'h0000;
				end else if (~line.scl) begin
					d.tmr = 16'h0000;
				end
			end
			SG_STOP1: begin
				if (tmr_end) begin
					d.sg = SG_STOP2;
					d.tmr = 16'h0000;
				end
			end
			SG_STOP2: begin
				if (~line.scl) begin
					d.tmr = 16'h0000;
				end else if (tmr_end) begin
					d.sg = SG_STOP3;
					d.sda_drv = 1'b0;
					d.tmr = 16'h0000;
				end
			end
			SG_STOP3: begin
				if (tmr_end) begin
					d.sg = SG_IDLE;
					d.master = 1'b0;
				end
			end
			SG_RS1: begin
				if (tmr_end) begin
					d.sg = SG_RS2;
					d.tmr = 16'h0000;
				end
			end
			SG_RS2: begin
				if (~line.scl) begin
					d.tmr = 16'h0000;
				end else if (tmr_end) begin
					d.sg = SG_START;
					d.sda_drv = 1'b1;
					d.tmr = 16'h0000;
				end
			end
			default: d.sg = SG_IDLE;
		endcase

		// disabled block drives nothing
		if (~d.en) begin
			d.master = 1'b0;
			d.master_select = 1'b0;
			d.ph = PH_IDLE;
			d.sg = SG_IDLE;
			d.sda_drv = 1'b0;
			d.stop_req = 1'b0;
			d.rs_req = 1'b0;
		end
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
			q.own <= ADDR_RST;
			q.div <= DIV_RST;
			q.rxd <= DATA_RST;
			q.ph <= PH_IDLE;
			q.sg <= SG_IDLE;
		end else begin
			q <= d;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign prdata = q.prdata;
	assign pready = 1'b1;
	assign pslverr = acc & ~hit;
	assign scl_o = 1'b0;
	assign sda_o = 1'b0;
	assign sda_oe = q.en & q.sda_drv;
	assign scl_oe = q.en & (((q.sg == SG_LOW) | (q.sg == SG_STOP1) |
		(q.sg == SG_RS1)) | (~q.master & (q.ph == PH_HOLD)));
endmodule

// ---- sim/i2cb_top_sva.sv ----
// port assertions for the byte controller
`timescale 1ns/1ps
module i2cb_chk import i2cb_pkg::*; (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic scl_i,
	input wire logic scl_o,
	input wire logic scl_oe,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic acc;
	logic hit;
	assign acc = psel && penable;
	assign hit = paddr inside {OFS_DATA, OFS_CTRL, OFS_STAT, OFS_ADDR, OFS_DIV};
	// ****
	// bus and line checks
	// ****
	zero_wait_a: assert property (psel |-> pready)
		else $error("pready low in transfer");
	unmapped_err_a: assert property (acc && !hit |-> pslverr)
		else $error("no error on unmapped address");
	mapped_ok_a: assert property (acc && hit |-> !pslverr)
		else $error("error on mapped address");
	rdata_hold_a: assert property (acc |=> $stable(prdata))
		else $error("read data moved after access");
	reset_quiet_a: assert property ($rose(rst_n) |->
		!scl_oe && !sda_oe && prdata == '0)
		else $error("lines or data active after reset");
	open_drain_a: assert property (scl_o == 1'b0 && sda_o == 1'b0)
		else $error("line driven high");
	start_free_a: assert property ($rose(sda_oe) && scl_i |->
		$past(sda_i))
		else $error("start on a busy data line");
	stop_quiet_a: assert property ($fell(sda_oe) && scl_i |=>
		(!scl_oe && !sda_oe) [*2])
		else $error("bus not freed after stop");
	scl_low_a: assert property ($rose(scl_oe) |=> scl_oe [*3])
		else $error("clock low phase too short");
	scl_high_a: assert property ($fell(scl_oe) |=> !scl_oe [*3])
		else $error("clock pulled before high counted");
endmodule
bind i2cb_top i2cb_chk u_i2cb_chk (.*);

// ---- sim/i2cb_peer.sv ----
// behavioural slave on the two-wire bus
`timescale 1ns/1ps
module i2cb_peer #(
	parameter logic [6:0] ADR = 7'h5a,
	parameter logic [7:0] TXB = 8'h3c
) (
	input wire logic scl,
	input wire logic sda,
	output logic scl_oe,
	output logic sda_oe,
	output logic [7:0] got
);
	logic [3:0] n;
	logic [7:0] sh;
	logic on, fst, rd, ak;
	// ****
	// framing, shift, ack and stretch
	// ****
	initial begin
		{scl_oe, sda_oe, on, fst, rd, ak, n, sh, got} = '0;
	end
	always @(negedge sda) if (scl) {on, fst, n} = {2'b11, 4'hf};
	always @(posedge sda) if (scl) on = 0;
	always @(posedge scl) if (n < 8) sh = {sh[6:0], sda}; else ak = sda;
	always @(negedge scl) if (on) begin
		n = n + 4'h1;
		if (n == 9) begin
			n = 0;
			if (fst) {on, rd} = {sh[7:1] == ADR, sh[0]};
			else if (!rd) got = sh;
			else on = !ak;
			fst = 0;
		end
		if (n == 8) sda_oe = on && (fst ? sh[7:1] == ADR : !rd);
		else sda_oe = on && rd && !fst && !TXB[3'd7 - n[2:0]];
		if (n == 0 && on) begin
			scl_oe = 1;
			#40 scl_oe = 0;
		end
	end
endmodule

// ---- sim/tb_top.sv ----
// self-checking bench for the byte controller
`timescale 1ns/1ps
module tb_top import i2cb_pkg::*; ();
	localparam logic [6:0] PADR = 7'h5a;
	localparam logic [7:0] PTX = 8'h3c;
	localparam logic [31:0] EN = 32'h1 << CB_EN;
	localparam logic [31:0] MS = 32'h1 << CB_MST;
	localparam logic [31:0] TX = 32'h1 << CB_TX;
	localparam logic [31:0] NA = 32'h1 << CB_ACK_DRIVE_VALUE;
	localparam logic [31:0] RS = 32'h1 << CB_RSTA;
	logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rdat;
	logic pready, pslverr, rerr, scl_oe, sda_oe, scl_o, sda_o;
	logic p_scl, p_sda, scl, sda;
	logic [7:0] got;
	int n_fail = 0, n_checks = 0;
	assign scl = !p_scl && !(scl_oe && !scl_o);
	assign sda = !p_sda && !(sda_oe && !sda_o);
	always #2 clk = ~clk;
	i2cb_top u_i2cb_top (.clk(clk), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_i(scl),
		.scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o),
		.sda_oe(sda_oe));
	i2cb_peer #(.ADR(PADR), .TXB(PTX)) u_i2cb_peer (.scl(scl), .sda(sda),
		.scl_oe(p_scl), .sda_oe(p_sda), .got(got));
	// ****
	// bus tasks
	// ****
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge clk);
		penable <= 1;
		do @(posedge clk); while (pready !== 1'b1);
		{rdat, rerr} = {prdata, pslverr};
		{psel, penable} <= 2'b00;
	endtask
	task automatic ck(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		apb(0, a, 0);
		ck(rdat & m, e);
	endtask
	task automatic transfer_complete_flag();
		rdat = 0;
		for (int i = 0; i < 300 && !rdat[SB_TCF]; i++) apb(0, OFS_STAT, 0);
	endtask
	task automatic close_out();
		if (n_fail == 0 && n_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// ****
	// scenarios
	// ****
	task automatic t_reset();
		rdc(OFS_DATA, '1, 32'h0);
		rdc(OFS_CTRL, '1, 32'h0);
		rdc(OFS_STAT, '1, 32'h0);
		rdc(OFS_ADDR, '1, 32'h0);
		rdc(OFS_DIV, '1, 32'h1f4);
		rdc(8'h20, '1, 32'h0);
		ck({31'h0, rerr}, 32'h1);
	endtask
	task automatic t_write();
		apb(1, OFS_DIV, 32'h7);
		apb(1, OFS_ADDR, 32'h22);
		apb(1, OFS_CTRL, EN | MS | TX);
		repeat (4) @(posedge clk);
		rdc(OFS_STAT, 32'h20, 32'h20);
		apb(1, OFS_DATA, {24'h0, PADR, 1'b0});
		transfer_complete_flag();
		ck(rdat & 32'h81, 32'h80);
		rdc(OFS_DATA, '1, 32'h0);
		rdc(OFS_STAT, 32'h80, 32'h80);
		apb(1, OFS_DATA, 32'ha5);
		rdc(OFS_STAT, 32'h80, 32'h0);
		transfer_complete_flag();
		ck({24'h0, got}, 32'ha5);
		apb(1, OFS_CTRL, EN);
		repeat (60) @(posedge clk);
		rdc(OFS_STAT, 32'h20, 32'h0);
	endtask
	task automatic t_read();
		apb(1, OFS_CTRL, EN | MS | TX);
		apb(1, OFS_DATA, 32'h66);
		transfer_complete_flag();
		ck(rdat & 32'h81, 32'h81);
		apb(1, OFS_CTRL, EN | MS | TX | RS);
		apb(1, OFS_DATA, {24'h0, PADR, 1'b1});
		transfer_complete_flag();
		ck(rdat & 32'h81, 32'h80);
		apb(1, OFS_CTRL, EN | MS | NA);
		apb(0, OFS_DATA, 0);
		transfer_complete_flag();
		ck(rdat & 32'h80, 32'h80);
		apb(1, OFS_CTRL, EN | MS | TX);
		rdc(OFS_DATA, '1, {24'h0, PTX});
		ck({31'h0, p_sda}, 32'h0);
		rdc(OFS_STAT, 32'h80, 32'h80);
		apb(1, OFS_CTRL, EN);
		repeat (60) @(posedge clk);
	endtask
	task automatic t_arb();
		apb(1, OFS_CTRL, EN | RS);
		rdc(OFS_STAT, 32'h10, 32'h10);
		apb(1, OFS_STAT, 32'h10);
		rdc(OFS_STAT, 32'h10, 32'h0);
	endtask
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1;
		t_reset();
		t_write();
		t_read();
		t_arb();
		close_out();
	end
	initial begin
		#100000;
		n_fail++;
		close_out();
	end
endmodule
